// ---- sim/line_trigger_gating_monitor_test.sv ----
// Self-checking bench: APB register access plus trigger source model.
// Assumes APB slave answers via pready and triggers are edge detected.
module line_trigger_gating_monitor_test;
    import ltg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXP = 3;
    localparam int ACQ = 2;
    localparam int LIN = 0;
    localparam int FRM = 1;
    localparam logic [31:0] EXP_CYC = 32'h000000c8;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    trig_t hw_trig;
    trig_t fire;
    logic strict;
    monitor_t monitor;
    logic [OUT_LINES-1:0] out_lines;
    logic [3:0] mv;
    logic [31:0] q;
    logic ovl;
    logic err;
    int fails;
    int n_compared;
    int n;
    line_trigger_gating_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_trig(hw_trig),
        .monitor(monitor), .out_lines(out_lines), .overlapped(ovl));
    trig_source src (.pclk(pclk), .presetn(presetn), .fire(fire), .strict(strict),
        .monitor(monitor), .hw_trig(hw_trig));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic timeout();
        check(32'h0, 32'h1);
        final_report();
    endtask : timeout
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) timeout();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic fire_trig(input trig_t t, input logic s);
        @(posedge pclk);
        fire <= t;
        strict <= s;
        @(posedge pclk);
        fire <= '0;
    endtask : fire_trig
    task automatic wait_mon(input int idx, input logic v);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            mv = monitor;
            if (mv[idx] === v) break;
        end
        if (i == 3000) timeout();
    endtask : wait_mon
    // Counts edges for which a monitor bit keeps its value
    task automatic count_while(input int idx, input logic v);
        n = 0;
        do begin
            @(posedge pclk);
            mv = monitor;
            n++;
        end while (mv[idx] === v && n < 5000);
    endtask : count_while
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fire = '0;
        strict = 1'b1;
        fails = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check({30'h0, out_lines}, 32'h0);
        check({28'h0, monitor}, 32'h0);
        $display("test reset done");
        // Exposure well above the least allowed time
        apb(1'b1, EXPOSURE_OFS, EXP_CYC);
        apb(1'b1, OVERLAP_OFS, 32'(LINE_PERIOD_RST) - GUARD_DEFAULT_CYC);
        apb(1'b1, LINES_OFS, 32'h00000010);
        apb(1'b1, CTRL_OFS, 32'h00000001);
        wait_mon(ACQ, 1'b1);
        check({28'h0, monitor}, 32'h4);
        check({31'h0, ovl}, 32'h0);
        // Line trigger while only acquisition start is awaited
        fire_trig(3'b001, 1'b0);
        repeat (10) @(posedge pclk);
        check({28'h0, monitor}, 32'h4);
        apb(1'b0, OVERTRIG_OFS, 32'h0);
        check({31'h0, q[0]}, 32'h1);
        $display("test early line trigger done");
        fire_trig(3'b100, 1'b1);
        wait_mon(LIN, 1'b1);
        check({31'h0, monitor.acq_wait}, 32'h0);
        check({31'h0, monitor.frame_wait}, 32'h0);
        // Line period honoured by waiting for the line wait output
        fire_trig(3'b001, 1'b1);
        wait_mon(EXP, 1'b1);
        check({31'h0, monitor.line_wait}, 32'h0);
        check({31'h0, out_lines[0]}, 32'h1);
        count_while(EXP, 1'b1);
        check(n, EXP_CYC);
        count_while(LIN, 1'b0);
        check({31'h0, n >= GUARD_DEFAULT_CYC}, 32'h1);
        $display("test exposure and guard done");
        // Acquisition and frame triggers while lines are being taken
        fire_trig(3'b110, 1'b0);
        repeat (10) @(posedge pclk);
        apb(1'b0, OVERTRIG_OFS, 32'h0);
        check({29'h0, q[2:0]}, 32'h7);
        apb(1'b1, OVERTRIG_OFS, 32'h00000007);
        apb(1'b0, OVERTRIG_OFS, 32'h0);
        check({29'h0, q[2:0]}, 32'h0);
        $display("test overtrigger flags done");
        apb(1'b1, OUTSEL_OFS, {28'h0, SRC_EXPOSURE, SRC_LINE_WAIT});
        repeat (2) @(posedge pclk);
        check({30'h0, out_lines}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test output select done");
        // Frame triggering, trigger width mode and the guard limit removed
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, LINE_PERIOD_OFS, 32'h00000064);
        repeat (2) @(posedge pclk);
        check({31'h0, ovl}, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0000000f);
        wait_mon(ACQ, 1'b1);
        fire_trig(3'b100, 1'b1);
        wait_mon(FRM, 1'b1);
        check({28'h0, monitor}, 32'h2);
        fire_trig(3'b010, 1'b1);
        wait_mon(LIN, 1'b1);
        fire_trig(3'b001, 1'b1);
        wait_mon(EXP, 1'b1);
        count_while(EXP, 1'b1);
        check(n, MIN_EXPOSURE_CYC);
        count_while(LIN, 1'b0);
        check(n, GUARD_UNLIMITED_CYC);
        $display("test frame and width mode done");
        final_report();
    end
endmodule : line_trigger_gating_monitor_test

// ---- sim/trig_source.sv ----
// Model of the external trigger source driving the three hardware triggers.
// Assumes pclk-synchronous triggers; each pulse is held HOLD cycles high.
module trig_source
    import ltg_pkg::*;
#(
    parameter int unsigned HOLD = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire trig_t fire,
    input wire logic strict,
    input wire monitor_t monitor,
    output trig_t hw_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ready;
    logic [2:0] pend;
    logic [2:0] drv;
    int unsigned cnt [3];
    assign ready = {monitor.acq_wait, monitor.frame_wait, monitor.line_wait};
    assign hw_trig = drv;
    // Strict mode waits for the matching wait output; otherwise fires at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 3'h0;
            drv <= 3'h0;
            for (int i = 0; i < 3; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (drv[i]) begin
                    if (cnt[i] == HOLD - 1) begin
                        drv[i] <= 1'b0;
                        cnt[i] <= 0;
                    end else begin
                        cnt[i] <= cnt[i] + 1;
                    end
                end else if (pend[i] && (!strict || ready[i])) begin
                    drv[i] <= 1'b1;
                    pend[i] <= 1'b0;
                end else if (fire[i]) begin
                    pend[i] <= 1'b1;
                end
            end
        end
    end
endmodule : trig_source

// ---- src/line_trigger_gating_monitor.sv ----
// Line trigger gating monitor: accepts hardware triggers only while waiting,
// times exposure, guard and readout, and flags discarded triggers.
// Assumes triggers are synchronous to pclk; registers reached over APB.
//
// Our own choices: the APB interface to the registers and the register offsets.
module line_trigger_gating_monitor
    import ltg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire trig_t hw_trig,
    output monitor_t monitor,
    output logic [OUT_LINES-1:0] out_lines,
    output logic overlapped
);
    state_t s_r;
    state_t s_nxt;
    logic wr;
    logic rd;
    logic mapped;
    trig_t rise;
    logic line_ok;
    logic start_exp;
    logic end_exp;
    logic trig_fall;
    logic [CNT_W-1:0] guard_len;

    function automatic logic [CNT_W-1:0] sat_dec(input logic [CNT_W-1:0] v);
        sat_dec = (v == '0) ? '0 : v - 1'b1;
    endfunction : sat_dec

    function automatic logic [CNT_W-1:0] max_cnt(input logic [CNT_W-1:0] a,
                                                 input logic [CNT_W-1:0] b);
        max_cnt = (a > b) ? a : b;
    endfunction : max_cnt

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    // Read data taken in setup so it stands through the access phase
    assign rd = psel & ~penable & ~pwrite;
    always_comb begin
        case (paddr)
            CTRL_OFS, EXPOSURE_OFS, LINE_PERIOD_OFS, OVERLAP_OFS,
            LINES_OFS, STATUS_OFS, OVERTRIG_OFS, OUTSEL_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    assign rise = hw_trig & ~s_r.trig_prev;
    assign trig_fall = s_r.trig_prev.line_start & ~hw_trig.line_start;

    // Guard stretched when the ceiling is set below period minus guard
    always_comb begin
        logic [CNT_W-1:0] base;
        logic [CNT_W-1:0] room;
        base = s_r.unlimit ? CNT_W'(GUARD_UNLIMITED_CYC) : CNT_W'(GUARD_DEFAULT_CYC);
        room = (s_r.line_period > s_r.overlap) ? s_r.line_period - s_r.overlap : '0;
        guard_len = max_cnt(base, room);
        // A ceiling above its proper value shrinks room; base still holds
    end

    // Line accepted only when idle of exposure and guard
    assign line_ok = (s_r.seq == ST_LINES) && !s_r.exposing && (s_r.guard_cnt == '0)
                     && (s_r.period_cnt == '0);
    assign start_exp = line_ok & rise.line_start;
    // Timed end at count, or width mode end at valid fall after readout
    assign end_exp = s_r.exposing &&
        (s_r.width_mode ? ((trig_fall || s_r.pending_end) && !s_r.readout
                           && (s_r.exp_cnt == '0))
                        : (s_r.exp_cnt == '0));
    // Longer exposure brings exposure plus guard nearer the period, so overlapped sets sooner
    // Readout lasts one guard length, so the sum is fixed per setting
    assign overlapped = (s_r.line_period <= s_r.exposure + guard_len);

    always_comb begin
        s_nxt = s_r;
        s_nxt.trig_prev = hw_trig;
        s_nxt.guard_cnt = sat_dec(s_r.guard_cnt);
        s_nxt.read_cnt = sat_dec(s_r.read_cnt);
        s_nxt.readout = s_r.readout && (s_r.read_cnt > CNT_W'(1));
        s_nxt.period_cnt = sat_dec(s_r.period_cnt);
        if (s_r.exposing) begin
            s_nxt.exp_cnt = sat_dec(s_r.exp_cnt);
        end

        case (s_r.seq)
            ST_IDLE: begin
                if (s_r.enable) begin
                    s_nxt.seq = ST_ACQ_WAIT;
                end
            end
            ST_ACQ_WAIT: begin
                if (rise.acq_start) begin
                    s_nxt.seq = s_r.frame_trig ? ST_FRAME_WAIT : ST_LINES;
                    s_nxt.line_cnt = s_r.lines;
                end
            end
            ST_FRAME_WAIT: begin
                if (rise.frame_start) begin
                    s_nxt.seq = ST_LINES;
                    s_nxt.line_cnt = s_r.lines;
                end
            end
            ST_LINES: begin
                if (start_exp) begin
                    s_nxt.exposing = 1'b1;
                    s_nxt.pending_end = 1'b0;
                    // Minimum width held even in width mode
                    s_nxt.exp_cnt = s_r.width_mode ? CNT_W'(MIN_EXPOSURE_CYC - 1)
                                                   : sat_dec(max_cnt(s_r.exposure,
                                                     CNT_W'(MIN_EXPOSURE_CYC)));
                    s_nxt.period_cnt = sat_dec(s_r.line_period);
                    s_nxt.line_cnt = s_r.line_cnt - 16'h0001;
                end
                if (!s_r.enable) begin
                    s_nxt.seq = ST_IDLE;
                end else if (s_r.line_cnt == 16'h0000 && !s_r.exposing
                             && s_r.guard_cnt == '0) begin
                    s_nxt.seq = s_r.frame_trig ? ST_FRAME_WAIT : ST_ACQ_WAIT;
                end
            end
            default: s_nxt.seq = ST_IDLE;
        endcase

        if (s_r.exposing && s_r.width_mode && trig_fall && !end_exp) begin
            s_nxt.pending_end = 1'b1;
        end
        if (end_exp) begin
            s_nxt.exposing = 1'b0;
            s_nxt.pending_end = 1'b0;
            s_nxt.guard_cnt = guard_len;
            s_nxt.readout = 1'b1;
            s_nxt.read_cnt = guard_len;
        end

        // Sticky flags; set wins over clear
        if (wr && paddr == OVERTRIG_OFS) begin
            s_nxt.overtrig = s_r.overtrig & ~trig_t'(pwdata[2:0]);
        end
        if (rise.acq_start && s_r.seq != ST_ACQ_WAIT) begin
            s_nxt.overtrig.acq_start = 1'b1;
        end
        if (rise.frame_start && s_r.seq != ST_FRAME_WAIT) begin
            s_nxt.overtrig.frame_start = 1'b1;
        end
        if (rise.line_start && !line_ok) begin
            s_nxt.overtrig.line_start = 1'b1;
        end

        if (wr) begin
            case (paddr)
                CTRL_OFS: begin
                    s_nxt.enable = pstrb[0] ? pwdata[CTRL_ENABLE_BIT] : s_r.enable;
                    s_nxt.width_mode = pstrb[0] ? pwdata[CTRL_WIDTH_MODE_BIT] : s_r.width_mode;
                    s_nxt.unlimit = pstrb[0] ? pwdata[CTRL_UNLIMIT_BIT] : s_r.unlimit;
                    s_nxt.frame_trig = pstrb[0] ? pwdata[CTRL_FRAME_TRIG_BIT] : s_r.frame_trig;
                end
                EXPOSURE_OFS: s_nxt.exposure = CNT_W'(merge(32'(s_r.exposure), pwdata, pstrb));
                LINE_PERIOD_OFS:
                    s_nxt.line_period = CNT_W'(merge(32'(s_r.line_period), pwdata, pstrb));
                OVERLAP_OFS: s_nxt.overlap = CNT_W'(merge(32'(s_r.overlap), pwdata, pstrb));
                LINES_OFS: s_nxt.lines = 16'(merge(32'(s_r.lines), pwdata, pstrb));
                OUTSEL_OFS: begin
                    if (pstrb[0]) begin
                        s_nxt.out_sel[0] = out_src_t'(pwdata[1:0]);
                        s_nxt.out_sel[1] = out_src_t'(pwdata[3:2]);
                    end
                end
                default: ;
            endcase
        end

        // Held between reads so the sampling edge never sees it change
        if (rd) begin
            s_nxt.prdata = '0;
            case (paddr)
                CTRL_OFS: s_nxt.prdata = {28'h0000000, s_r.frame_trig, s_r.unlimit,
                                          s_r.width_mode, s_r.enable};
                EXPOSURE_OFS: s_nxt.prdata = 32'(s_r.exposure);
                LINE_PERIOD_OFS: s_nxt.prdata = 32'(s_r.line_period);
                OVERLAP_OFS: s_nxt.prdata = 32'(s_r.overlap);
                LINES_OFS: s_nxt.prdata = 32'(s_r.lines);
                STATUS_OFS: s_nxt.prdata = {26'h0, overlapped, s_r.readout,
                                            s_r.mon};
                OVERTRIG_OFS: s_nxt.prdata = 32'(s_r.overtrig);
                OUTSEL_OFS: s_nxt.prdata = 32'(s_r.out_sel);
                default: ;
            endcase
        end

        // Monitors follow next state so they track the state exactly
        s_nxt.mon.exposure_active = s_nxt.exposing;
        s_nxt.mon.acq_wait = (s_nxt.seq == ST_ACQ_WAIT);
        s_nxt.mon.frame_wait = (s_nxt.seq == ST_FRAME_WAIT);
        s_nxt.mon.line_wait = (s_nxt.seq == ST_LINES) && !s_nxt.exposing
                              && (s_nxt.guard_cnt == '0) && (s_nxt.period_cnt == '0);
        for (int i = 0; i < OUT_LINES; i++) begin
            case (s_nxt.out_sel[i])
                SRC_EXPOSURE: s_nxt.out_lines[i] = s_nxt.mon.exposure_active;
                SRC_ACQ_WAIT: s_nxt.out_lines[i] = s_nxt.mon.acq_wait;
                SRC_FRAME_WAIT: s_nxt.out_lines[i] = s_nxt.mon.frame_wait;
                default: s_nxt.out_lines[i] = s_nxt.mon.line_wait;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.exposure <= EXPOSURE_RST;
            s_r.line_period <= LINE_PERIOD_RST;
            s_r.overlap <= OVERLAP_RST;
            s_r.lines <= LINES_RST;
            s_r.out_sel[0] <= OUT1_RST;
            s_r.out_sel[1] <= OUT2_RST;
            s_r.seq <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign monitor = s_r.mon;
    assign out_lines = s_r.out_lines;

    property p_line_wait_state;
        @(posedge pclk) disable iff (!presetn)
        monitor.line_wait |-> (s_r.seq == ST_LINES) && !s_r.exposing;
    endproperty : p_line_wait_state
    a_line_wait_state: assert property (p_line_wait_state)
        else $error("line wait high outside line state");

    property p_acq_wait;
        @(posedge pclk) disable iff (!presetn)
        monitor.acq_wait == (s_r.seq == ST_ACQ_WAIT);
    endproperty : p_acq_wait
    a_acq_wait: assert property (p_acq_wait)
        else $error("acquisition wait mismatch");

    property p_frame_wait;
        @(posedge pclk) disable iff (!presetn)
        monitor.frame_wait == (s_r.seq == ST_FRAME_WAIT);
    endproperty : p_frame_wait
    a_frame_wait: assert property (p_frame_wait)
        else $error("frame wait mismatch");

    // Refused triggers: discarded, and flagged on the next edge
    sequence s_acq_refused;
        rise.acq_start && !monitor.acq_wait;
    endsequence : s_acq_refused
    sequence s_frame_refused;
        rise.frame_start && !monitor.frame_wait;
    endsequence : s_frame_refused
    sequence s_line_refused;
        rise.line_start && !monitor.line_wait && !monitor.exposure_active;
    endsequence : s_line_refused

    property p_acq_refused;
        @(posedge pclk) disable iff (!presetn)
        s_acq_refused |=> s_r.overtrig.acq_start;
    endproperty : p_acq_refused
    a_acq_refused: assert property (p_acq_refused)
        else $error("acquisition overtrigger not flagged");

    property p_frame_refused;
        @(posedge pclk) disable iff (!presetn)
        s_frame_refused |=> s_r.overtrig.frame_start;
    endproperty : p_frame_refused
    a_frame_refused: assert property (p_frame_refused)
        else $error("frame overtrigger not flagged");

    property p_line_refused;
        @(posedge pclk) disable iff (!presetn)
        s_line_refused |=> !monitor.exposure_active && s_r.overtrig.line_start;
    endproperty : p_line_refused
    a_line_refused: assert property (p_line_refused)
        else $error("refused line trigger started exposure or was not flagged");

    // Shortest guard is the unlimited one; line wait must stay low in it
    property p_guard_after_exposure;
        @(posedge pclk) disable iff (!presetn)
        $fell(monitor.exposure_active) |->
            !monitor.line_wait && (s_r.guard_cnt >= CNT_W'(GUARD_UNLIMITED_CYC));
    endproperty : p_guard_after_exposure
    a_guard_after_exposure: assert property (p_guard_after_exposure)
        else $error("guard period missing after exposure");
endmodule : line_trigger_gating_monitor

// ---- src/ltg_pkg.sv ----
// Package for the line trigger gating monitor: register map, field layout,
// timing constants and the packed types shared by the design.
// Assumes a 50 MHz pclk and 32-bit APB data with word-aligned registers.
package ltg_pkg;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CLK_NS = 20;
    // Times in nanoseconds as printed
    localparam int unsigned MIN_EXPOSURE_NS = 2000;
    localparam int unsigned GUARD_DEFAULT_NS = 5400;
    localparam int unsigned GUARD_UNLIMITED_NS = 3400;
    // Least times round up
    localparam int unsigned MIN_EXPOSURE_CYC = (MIN_EXPOSURE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned GUARD_DEFAULT_CYC = (GUARD_DEFAULT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned GUARD_UNLIMITED_CYC = (GUARD_UNLIMITED_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] EXPOSURE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] LINE_PERIOD_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] OVERLAP_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] LINES_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] OVERTRIG_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] OUTSEL_OFS = 8'h1c;

    // Control fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_WIDTH_MODE_BIT = 1;
    localparam int unsigned CTRL_UNLIMIT_BIT = 2;
    localparam int unsigned CTRL_FRAME_TRIG_BIT = 3;

    // Reset values; overlap ceiling is min period minus default guard
    localparam logic [CNT_W-1:0] EXPOSURE_RST = 20'h00064;
    localparam logic [CNT_W-1:0] LINE_PERIOD_RST = 20'h003d9;
    localparam logic [CNT_W-1:0] OVERLAP_RST = 20'h002cb;
    localparam logic [15:0] LINES_RST = 16'h0003;

    // Output line source codes
    typedef enum logic [1:0] {
        SRC_EXPOSURE, SRC_ACQ_WAIT, SRC_FRAME_WAIT, SRC_LINE_WAIT
    } out_src_t;
    localparam int unsigned OUT_LINES = 2;
    localparam out_src_t OUT1_RST = SRC_EXPOSURE;
    localparam out_src_t OUT2_RST = SRC_LINE_WAIT;

    typedef enum logic [1:0] {
        ST_IDLE, ST_ACQ_WAIT, ST_FRAME_WAIT, ST_LINES
    } seq_st_t;

    typedef struct packed {
        logic acq_start;
        logic frame_start;
        logic line_start;
    } trig_t;

    typedef struct packed {
        logic exposure_active;
        logic acq_wait;
        logic frame_wait;
        logic line_wait;
    } monitor_t;

    typedef struct packed {
        logic enable;
        logic width_mode;
        logic unlimit;
        logic frame_trig;
        logic [CNT_W-1:0] exposure;
        logic [CNT_W-1:0] line_period;
        logic [CNT_W-1:0] overlap;
        logic [15:0] lines;
        out_src_t [OUT_LINES-1:0] out_sel;
        trig_t overtrig;
        seq_st_t seq;
        logic exposing;
        logic readout;
        logic pending_end;
        logic [CNT_W-1:0] exp_cnt;
        logic [CNT_W-1:0] guard_cnt;
        logic [CNT_W-1:0] read_cnt;
        logic [CNT_W-1:0] period_cnt;
        logic [15:0] line_cnt;
        trig_t trig_prev;
        logic [31:0] prdata;
        logic [OUT_LINES-1:0] out_lines;
        monitor_t mon;
    } state_t;
endpackage : ltg_pkg
